/* rtl/tpo_core.sv */
`timescale 1ns/1ps
module tpo_core
  import tpo_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES  // Clocks per millisecond
) (
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  input  wire tpo_cfg_type    heat_cfg_i,      // Channel 1 settings
  input  wire tpo_cfg_type    cool_cfg_i,      // Channel 2 settings
  input  wire logic           heat_cool_en_i,  // Heating/cooling in use
  input  wire logic           cycle_policy_i,  // 1: one switch per cycle
  input  wire logic           cfg_wr_i,        // Load cycle and policy
  output logic                heat_out_o,      // Channel 1 drive
  output logic                cool_out_o,      // Channel 2 drive
  output logic                policy_o,        // Policy in force
  output logic [6:0]          heat_cyc_o,      // Channel 1 cycle, s
  output logic [6:0]          cool_cyc_o       // Channel 2 cycle, s
);

  tpo_state_type st_r;       // All registered state
  tpo_state_type st_nxt;     // Its next value

  tpo_cfg_type   cfg_w    [NUM_CH];  // Settings by channel index
  logic [16:0]   period_w [NUM_CH];  // Resolved cycle, ms
  logic [7:0]    min_w    [NUM_CH];  // Resolved minimum, ms
  logic [16:0]   target_w [NUM_CH];  // ON time after limits, ms
  logic          active_w [NUM_CH];  // Channel runs at all
  logic          ms_tick_w;          // One clock each millisecond

  assign cfg_w[0] = heat_cfg_i;
  assign cfg_w[1] = cool_cfg_i;

  assign ms_tick_w = (st_r.tick_cnt == 16'(TICK_DIV - 1));

  // Resolve each channel's timing from its settings
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic        relay_w;     // Output includes a relay
    logic        slow_w;      // Relay or event output
    logic [6:0]  len_w;       // Cycle length after clamping
    logic [9:0]  dem_w;       // Demand after clamping
    logic [26:0] prod_w;      // Cycle times demand
    logic [16:0] raw_w;       // Unlimited ON time

    assign relay_w = (cfg_w[c].kind == TPO_OUT_RELAY);
    assign slow_w  = relay_w || (cfg_w[c].kind == TPO_OUT_EVENT);

    // Relays need a longer least cycle for contact wear
    always_comb begin
      len_w = st_r.cyc_len[c];
      if (relay_w && len_w < CYC_MIN_RLY) begin  // RQ3
        len_w = CYC_MIN_RLY;
      end else if (len_w < CYC_MIN_OTH) begin    // RQ3
        len_w = CYC_MIN_OTH;
      end else if (len_w > CYC_MAX) begin        // RQ3
        len_w = CYC_MAX;
      end
    end

    // Fixed sub-second cycles only for solid-state outputs
    always_comb begin
      if (relay_w) begin                         // RQ2
        period_w[c] = 17'(len_w * MS_PER_S);
      end else begin
        case (cfg_w[c].unit_sel)                 // RQ1
          2'h1:    period_w[c] = FIX_500_MS;
          2'h2:    period_w[c] = FIX_250_MS;
          2'h3:    period_w[c] = FIX_100_MS;
          default: period_w[c] = 17'(len_w * MS_PER_S);
        endcase
      end
    end

    // Minimum ON/OFF time
    always_comb begin
      if (cfg_w[c].min_ms == 8'h00) begin
        min_w[c] = (slow_w || period_w[c] >= LONG_CYC_MS) ?
                   MIN_SLOW_MS : MIN_FAST_MS;      // RQ5
      end else if (slow_w && cfg_w[c].min_ms < MIN_RLY_MS) begin
        min_w[c] = MIN_RLY_MS;                     // RQ6
      end else if (cfg_w[c].min_ms > MIN_MAX_MS) begin
        min_w[c] = MIN_MAX_MS;                     // RQ6
      end else begin
        min_w[c] = cfg_w[c].min_ms;                // RQ6
      end
    end

    // ON time from demand; short slivers are folded away
    assign dem_w  = (cfg_w[c].demand > DEMAND_FULL) ?
                    DEMAND_FULL : cfg_w[c].demand;  // RQ11
    // Both operands widened first so the product keeps every bit
    assign prod_w = {10'h000, period_w[c]} * {17'h00000, dem_w};
    assign raw_w  = 17'(prod_w / DEMAND_DIV);       // RQ11
    always_comb begin
      if (raw_w < 17'(min_w[c])) begin
        target_w[c] = MS_RST;                       // RQ12
      end else if (period_w[c] - raw_w < 17'(min_w[c])) begin
        target_w[c] = period_w[c];                  // RQ12
      end else begin
        target_w[c] = raw_w;
      end
    end

    // Cooling channel runs only in heating/cooling control
    assign active_w[c] = (cfg_w[c].kind != TPO_OUT_NONE) &&   // RQ8
                         (c == 0 || heat_cool_en_i);          // RQ7
  end

  // Next-state logic for the whole block
  always_comb begin
    logic [16:0] ms_v;   // Cycle position after this tick
    logic [16:0] on_v;   // ON time in force this tick
    logic        want_v; // Level the demand asks for
    st_nxt = st_r;
    ms_v   = MS_RST;
    on_v   = MS_RST;
    want_v = 1'b0;

    st_nxt.tick_cnt = ms_tick_w ? TICK_RST : st_r.tick_cnt + 16'h0001;

    // Factory values first clock after reset, keyed to output kind
    if (!st_r.init_done) begin
      st_nxt.init_done = 1'b1;
      st_nxt.policy    = (heat_cfg_i.kind != TPO_OUT_VPULSE);  // RQ10
      for (int c = 0; c < NUM_CH; c++) begin
        st_nxt.cyc_len[c] = (cfg_w[c].kind == TPO_OUT_VPULSE) ?
                            CYC_DEF_VP : CYC_DEF_OTH;          // RQ4 RQ7
      end
    end else if (cfg_wr_i) begin
      st_nxt.policy     = cycle_policy_i;                      // RQ9
      st_nxt.cyc_len[0] = heat_cfg_i.cyc_len;
      st_nxt.cyc_len[1] = cool_cfg_i.cyc_len;
    end

    for (int c = 0; c < NUM_CH; c++) begin
      if (!active_w[c]) begin
        // Idle channel parks low and restarts its cycle
        st_nxt.ch[c].out    = 1'b0;
        st_nxt.ch[c].ms_cnt = MS_RST;
        st_nxt.ch[c].on_ms  = MS_RST;
      end else if (ms_tick_w) begin
        if (st_r.ch[c].hold != HOLD_RST) begin
          st_nxt.ch[c].hold = st_r.ch[c].hold + 8'h01;
        end
        if (st_r.ch[c].ms_cnt + 17'h00001 >= period_w[c]) begin
          ms_v = MS_RST;
          st_nxt.ch[c].on_ms = target_w[c];
          on_v = target_w[c];
        end else begin
          ms_v = st_r.ch[c].ms_cnt + 17'h00001;
          on_v = st_r.ch[c].on_ms;
        end
        st_nxt.ch[c].ms_cnt = ms_v;
        // Life policy holds the ON time for the whole cycle,
        // trading response for one edge pair per cycle
        want_v = st_r.policy ? (ms_v < on_v)            // RQ9
                             : (ms_v < target_w[c]);    // RQ11
        // An edge waits until the level has stood long enough
        if (want_v != st_r.ch[c].out &&
            st_r.ch[c].hold >= min_w[c]) begin           // RQ12
          st_nxt.ch[c].out  = want_v;
          st_nxt.ch[c].hold = 8'h00;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '{tick_cnt: TICK_RST, init_done: 1'b0, policy: 1'b1,
                cyc_len: {CYC_DEF_OTH, CYC_DEF_OTH},
                ch: '{default: '{ms_cnt: MS_RST, on_ms: MS_RST,
                                 hold: HOLD_RST, out: 1'b0}}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign heat_out_o = st_r.ch[0].out;
  assign cool_out_o = st_r.ch[1].out;
  assign policy_o   = st_r.policy;
  assign heat_cyc_o = st_r.cyc_len[0];
  assign cool_cyc_o = st_r.cyc_len[1];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  unit_fixed_a: assert property ( // RQ1
    cfg_w[0].kind == TPO_OUT_VPULSE && cfg_w[0].unit_sel == 2'h3
      |-> period_w[0] == FIX_100_MS)
    else $error("fixed 0.1 s cycle not applied");
  relay_unit_a: assert property ( // RQ2
    cfg_w[0].kind == TPO_OUT_RELAY
      |-> period_w[0] >= 17'(CYC_MIN_RLY * MS_PER_S))
    else $error("relay cycle below 5 s");
  cyc_range_a: assert property ( // RQ3
    period_w[1] <= 17'(CYC_MAX * MS_PER_S) && period_w[1] != MS_RST)
    else $error("cycle length out of range");
  init_dflt_a: assert property ( // RQ4
    $rose(st_r.init_done) && $past(heat_cfg_i.kind) == TPO_OUT_VPULSE
      |-> st_r.cyc_len[0] == CYC_DEF_VP && !st_r.policy)
    else $error("factory defaults wrong");
  min_zero_a: assert property ( // RQ5
    cfg_w[0].min_ms == 8'h00 && cfg_w[0].kind == TPO_OUT_EVENT
      |-> min_w[0] == MIN_SLOW_MS)
    else $error("zero minimum not 250 ms");
  min_raise_a: assert property ( // RQ6
    cfg_w[1].kind == TPO_OUT_RELAY && cfg_w[1].min_ms != 8'h00
      |-> min_w[1] >= MIN_RLY_MS)
    else $error("relay minimum below 50 ms");
  cool_off_a: assert property ( // RQ7
    !heat_cool_en_i |=> !cool_out_o)
    else $error("cooling output without heat/cool");
  none_off_a: assert property ( // RQ8
    heat_cfg_i.kind == TPO_OUT_NONE |=> !heat_out_o)
    else $error("unassigned output switched");
  // Parking an idle channel low is exempt from the spacing limit
  edge_space_a: assert property ( // RQ12
    $changed(heat_out_o) && $past(active_w[0])
      |-> $past(st_r.ch[0].hold) >= $past(min_w[0]))
    else $error("edge closer than minimum time");
  life_once_a: assert property ( // RQ9
    st_r.policy && $fell(heat_out_o) && st_r.ch[0].ms_cnt != MS_RST
      |-> st_r.ch[0].ms_cnt >= st_r.ch[0].on_ms)
    else $error("extra OFF edge in life mode");
  full_on_a: assert property ( // RQ11
    target_w[0] <= period_w[0])
    else $error("ON time exceeds cycle");

  heat_rise_c: cover property ($rose(heat_out_o));
  cool_rise_c: cover property (heat_cool_en_i && $rose(cool_out_o));
  wrap_c:      cover property (ms_tick_w && st_nxt.ch[0].ms_cnt == MS_RST);
  cfg_load_c:  cover property (cfg_wr_i && st_r.init_done);

endmodule

/* rtl/tpo_pkg.sv */
// Behaviour
// RQ1: Unit code picks 1 s or fixed cycle.
// RQ2: Unit code ignored on relay channels.
// RQ3: Cycle clamped 5-120 s relay, else 1-120.
// RQ4: Default cycle 2 s voltage pulse, else 10.
// RQ5: Zero minimum becomes 250 ms or 1 ms.
// RQ6: Relay/event minimum below 50 raised to 50.
// RQ7: Channel 2 same rules, cooling only.
// RQ8: Runs only on relay, pulse, event outputs.
// RQ9: Policy picks controllability or one switch/cycle.
// RQ10: Default policy 0 voltage pulse, else 1.
// RQ11: ON fraction equals clamped demand.
// RQ12: No pulse or gap below minimum time.
package tpo_pkg;

  // Timebase: system clock and one millisecond tick
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned TICK_MS      = 1;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;

  // Cycle lengths in milliseconds
  localparam logic [16:0] MS_PER_S     = 17'h003e8;  // 1000 ms
  localparam logic [16:0] FIX_500_MS   = 17'h001f4;
  localparam logic [16:0] FIX_250_MS   = 17'h000fa;
  localparam logic [16:0] FIX_100_MS   = 17'h00064;
  localparam logic [16:0] LONG_CYC_MS  = 17'h02710;  // 10 s

  // Cycle length limits and defaults in seconds
  localparam logic [6:0]  CYC_MIN_RLY  = 7'h05;
  localparam logic [6:0]  CYC_MIN_OTH  = 7'h01;
  localparam logic [6:0]  CYC_MAX      = 7'h78;      // 120 s
  localparam logic [6:0]  CYC_DEF_VP   = 7'h02;
  localparam logic [6:0]  CYC_DEF_OTH  = 7'h0a;

  // Minimum ON/OFF times in milliseconds
  localparam logic [7:0]  MIN_SLOW_MS  = 8'hfa;      // 250 ms
  localparam logic [7:0]  MIN_FAST_MS  = 8'h01;
  localparam logic [7:0]  MIN_RLY_MS   = 8'h32;      // 50 ms
  localparam logic [7:0]  MIN_MAX_MS   = 8'hfa;

  // Demand is in tenths of a percent
  localparam logic [9:0]  DEMAND_FULL  = 10'h3e8;    // 100.0 %
  localparam logic [26:0] DEMAND_DIV   = 27'h00003e8;

  // Reset values of the state
  localparam logic [15:0] TICK_RST     = 16'h0000;
  localparam logic [16:0] MS_RST       = 17'h00000;
  localparam logic [7:0]  HOLD_RST     = 8'hff;

  localparam int unsigned NUM_CH       = 2;

  // What a channel's output pin is assigned to
  typedef enum logic [1:0] {
    TPO_OUT_NONE,
    TPO_OUT_RELAY,
    TPO_OUT_VPULSE,
    TPO_OUT_EVENT
  } tpo_kind_type;

  // Per-channel setting bundle
  typedef struct packed {
    tpo_kind_type kind;      // Output assignment
    logic [1:0]   unit_sel;  // Cycle timebase code
    logic [6:0]   cyc_len;   // Cycle length, seconds
    logic [7:0]   min_ms;    // Minimum ON/OFF setting
    logic [9:0]   demand;    // Manipulated variable, 0.1 %
  } tpo_cfg_type;

  // Per-channel running state
  typedef struct packed {
    logic [16:0] ms_cnt;     // Position inside the cycle
    logic [16:0] on_ms;      // ON time latched at cycle start
    logic [7:0]  hold;       // Time since last edge, saturating
    logic        out;        // Output level
  } tpo_ch_type;

  // Whole block state
  typedef struct packed {
    logic [15:0]               tick_cnt;
    logic                      init_done;
    logic                      policy;
    logic [NUM_CH-1:0][6:0]    cyc_len;
    tpo_ch_type [NUM_CH-1:0]   ch;
  } tpo_state_type;

endpackage

/* verification/tpo_load.sv */
`timescale 1ns/1ps
// Actuator stand-in: times every pulse it is driven with, as a relay or
// voltage pulse load would see it; it never drives anything back.
module tpo_load (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        drive_i,     // Drive from one channel
  output logic [31:0]      on_clks_o,   // Length of last finished pulse
  output logic [31:0]      per_clks_o,  // Rise to rise of last cycle
  output logic [31:0]      rises_o      // Switch-on count, wear measure
);
  logic        drive_d;  // Drive one edge ago
  logic [31:0] hi_cnt;   // Clocks high in current pulse
  logic [31:0] per_cnt;  // Clocks since last rise

  // Edge timing; counts in clocks so one tick is TICK_DIV clocks
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_d    <= 1'b0;
      hi_cnt     <= 32'h0;
      per_cnt    <= 32'h0;
      on_clks_o  <= 32'h0;
      per_clks_o <= 32'h0;
      rises_o    <= 32'h0;
    end else begin
      drive_d <= drive_i;
      if (drive_i && !drive_d) begin
        // Switch-on closes one cycle and opens the next
        rises_o    <= rises_o + 32'h1;
        per_clks_o <= per_cnt;
        per_cnt    <= 32'h1;
        hi_cnt     <= 32'h1;
      end else begin
        per_cnt <= per_cnt + 32'h1;
        if (drive_i)
          hi_cnt <= hi_cnt + 32'h1;
        if (!drive_i && drive_d)
          on_clks_o <= hi_cnt;
      end
    end
  end
endmodule

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
  import tpo_pkg::*;
  // Short tick keeps second-long cycles affordable
  localparam int TK = 5;
  typedef struct {
    tpo_kind_type k;
    logic [1:0]   u;
    logic [7:0]   mn;
    logic [9:0]   d;
    int           on;   // Expected pulse clocks, 0 when none
    logic         lvl;  // Steady level when no pulse
  } tpo_case_type;
  logic        clk_i;
  logic        rst_n_i;
  tpo_cfg_type heat_cfg_i;
  tpo_cfg_type cool_cfg_i;
  logic        heat_cool_en_i;
  logic        cycle_policy_i;
  logic        cfg_wr_i;
  logic        heat_out_o;
  logic        cool_out_o;
  logic        policy_o;
  logic [6:0]  heat_cyc_o;
  logic [6:0]  cool_cyc_o;
  logic [31:0] h_on, h_per, h_rise, c_on, c_per, c_rise, r0;
  int          error_cnt;
  int          compares;
  int          pms [4] = '{1000, 500, 250, 100};  // Period per unit, ms
  tpo_case_type mc [5] = '{
    '{TPO_OUT_VPULSE, 2'h3, 8'h14, 10'h064, 0, 1'b0},
    '{TPO_OUT_VPULSE, 2'h3, 8'h14, 10'h384, 0, 1'b1},
    '{TPO_OUT_EVENT,  2'h3, 8'h0a, 10'h12c, 0, 1'b0},
    '{TPO_OUT_VPULSE, 2'h3, 8'h0a, 10'h12c, 150, 1'b0},
    '{TPO_OUT_EVENT,  2'h1, 8'h00, 10'h190, 0, 1'b0}};

  tpo_core #(.TICK_DIV(TK)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .heat_cfg_i(heat_cfg_i), .cool_cfg_i(cool_cfg_i),
    .heat_cool_en_i(heat_cool_en_i), .cycle_policy_i(cycle_policy_i),
    .cfg_wr_i(cfg_wr_i), .heat_out_o(heat_out_o), .cool_out_o(cool_out_o),
    .policy_o(policy_o), .heat_cyc_o(heat_cyc_o), .cool_cyc_o(cool_cyc_o));
  tpo_load heat_load (.clk_i(clk_i), .rst_n_i(rst_n_i), .drive_i(heat_out_o),
    .on_clks_o(h_on), .per_clks_o(h_per), .rises_o(h_rise));
  tpo_load cool_load (.clk_i(clk_i), .rst_n_i(rst_n_i), .drive_i(cool_out_o),
    .on_clks_o(c_on), .per_clks_o(c_per), .rises_o(c_rise));

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // One comparison, four-state exact
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Kinds must be set before release: defaults follow them
  task automatic do_reset(input tpo_kind_type hk, input tpo_kind_type ck);
    heat_cfg_i.kind = hk;
    cool_cfg_i.kind = ck;
    rst_n_i = 1'b0;
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
  endtask

  // One-cycle load of both cycle lengths and the policy
  task automatic write_cfg(input logic [6:0] hl, input logic [6:0] cl,
                           input logic pol);
    heat_cfg_i.cyc_len = hl;
    cool_cfg_i.cyc_len = cl;
    cycle_policy_i = pol;
    cfg_wr_i = 1'b1;
    @(negedge clk_i);
    cfg_wr_i = 1'b0;
    @(negedge clk_i);
  endtask

  // Live channel settings, then let ms milliseconds run
  task automatic setup(input bit ch, input tpo_kind_type k,
    input logic [1:0] u, input logic [7:0] mn, input logic [9:0] d,
    input int ms);
    if (ch) begin
      cool_cfg_i.kind = k;
      cool_cfg_i.unit_sel = u;
      cool_cfg_i.min_ms = mn;
      cool_cfg_i.demand = d;
    end else begin
      heat_cfg_i.kind = k;
      heat_cfg_i.unit_sel = u;
      heat_cfg_i.min_ms = mn;
      heat_cfg_i.demand = d;
    end
    repeat (ms * TK) @(negedge clk_i);
  endtask

  // Hang guard, a little above the planned run length
  initial begin
    #(1_960_000);
    error_cnt++;
    wrap_up();
  end

  initial begin
    error_cnt = 0;
    compares = 0;
    heat_cfg_i = '0;
    cool_cfg_i = '0;
    heat_cool_en_i = 1'b0;
    cycle_policy_i = 1'b0;
    cfg_wr_i = 1'b0;
    rst_n_i = 1'b0;
    // Factory values follow the output kinds
    do_reset(TPO_OUT_VPULSE, TPO_OUT_RELAY);
    chk("heat_cyc", 32'h2, 32'(heat_cyc_o));
    chk("cool_cyc", 32'ha, 32'(cool_cyc_o));
    chk("policy", 32'h0, 32'(policy_o));
    do_reset(TPO_OUT_RELAY, TPO_OUT_VPULSE);
    chk("heat_cyc", 32'ha, 32'(heat_cyc_o));
    chk("cool_cyc", 32'h2, 32'(cool_cyc_o));
    chk("policy", 32'h1, 32'(policy_o));
    write_cfg(7'h01, 7'h01, 1'b0);
    chk("heat_cyc", 32'h1, 32'(heat_cyc_o));
    chk("policy", 32'h0, 32'(policy_o));
    // Every unit code on a pulse output, half demand
    for (int u = 0; u < 4; u++) begin
      setup(0, TPO_OUT_VPULSE, u[1:0], 8'h01, 10'h1f4, 2 * pms[u] + 20);
      chk("heat_per", 32'(pms[u] * TK), h_per);
      chk("heat_on", 32'(pms[u] * TK / 2), h_on);
    end
    // Minimum ON/OFF resolution, including the zero setting
    foreach (mc[i]) begin
      setup(0, mc[i].k, mc[i].u, mc[i].mn, mc[i].d, 2 * pms[mc[i].u] + 20);
      r0 = h_rise;
      repeat (pms[mc[i].u] * TK) @(negedge clk_i);
      if (mc[i].on > 0) begin
        chk("heat_on", 32'(mc[i].on), h_on);
      end else begin
        chk("heat_rises", r0, h_rise);
        chk("heat_lvl", 32'(mc[i].lvl), 32'(heat_out_o));
      end
    end
    setup(0, TPO_OUT_VPULSE, 2'h1, 8'h00, 10'h190, 1020);
    chk("heat_on", 32'(200 * TK), h_on);
    // Life policy: ON time latched at cycle start, a demand cut waits
    write_cfg(7'h01, 7'h01, 1'b1);
    chk("policy", 32'h1, 32'(policy_o));
    setup(0, TPO_OUT_VPULSE, 2'h3, 8'h01, 10'h320, 220);
    @(posedge heat_out_o);
    repeat (10 * TK + 1) @(negedge clk_i);
    heat_cfg_i.demand = 10'h0c8;
    repeat (80 * TK) @(negedge clk_i);
    chk("heat_on", 32'(80 * TK), h_on);
    repeat (100 * TK) @(negedge clk_i);
    chk("heat_on", 32'(20 * TK), h_on);
    // Relay cooling: unit code ignored, 1 s setting clamped to 5 s
    setup(0, TPO_OUT_NONE, 2'h0, 8'h01, 10'h1f4, 0);
    heat_cool_en_i = 1'b1;
    r0 = h_rise;
    setup(1, TPO_OUT_RELAY, 2'h3, 8'h00, 10'h1f4, 10020);
    chk("cool_per", 32'(5000 * TK), c_per);
    chk("cool_on", 32'(2500 * TK), c_on);
    chk("heat_rises", r0, h_rise);
    chk("heat_lvl", 32'h0, 32'(heat_out_o));
    // Cooling channel idle without heating/cooling control
    heat_cool_en_i = 1'b0;
    setup(1, TPO_OUT_VPULSE, 2'h3, 8'h01, 10'h1f4, 20);
    r0 = c_rise;
    repeat (300 * TK) @(negedge clk_i);
    chk("cool_rises", r0, c_rise);
    chk("cool_lvl", 32'h0, 32'(cool_out_o));
    wrap_up();
  end
endmodule
